// File: rtl/mrs_defs.svh
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH
// ==========================================================
// Command codes
`define MRS_CMD_POS 8'hd5
`define MRS_CMD_NEG 8'hd6
// ==========================================================
// Ranges, presets and format
`define MRS_POS_MIN 16'h0000
`define MRS_POS_MAX 16'h001f
`define MRS_NEG_MIN 16'hffc0
`define MRS_NEG_MAX 16'hffff
`define MRS_POS_RST0 16'h0009
`define MRS_POS_RST1 16'h000f
`define MRS_NEG_RST0 16'hfff7
`define MRS_NEG_RST1 16'hfff1
`define MRS_STEP_UV 1953
`define MRS_SCALE_FRAC 7
`endif

// File: rtl/mrs_pkg.sv
package mrs_pkg;
	// Command port sequencer
	typedef enum logic [1:0]
	{
		MRS_IDLE = 2'b01,
		MRS_RESP = 2'b10
	} mrs_fsm_t;
	// Converter states as seen on conv_state_in
	typedef enum logic [3:0]
	{
		MRS_SOFT_START = 4'b0001,
		MRS_STEADY = 4'b0010,
		MRS_TOFF_DELAY = 4'b0100,
		MRS_SOFT_STOP = 4'b1000
	} mrs_conv_t;
endpackage

// File: rtl/mrs_ramp_if.sv
`timescale 1ns/1ns
interface mrs_ramp_if;
	logic [15:0] target;
	logic [15:0] step_div;
	logic run;
	logic [15:0] current;
	modport ctrl (output target, output step_div, output run, input current);
	modport ramp (input target, input step_div, input run, output current);
endinterface

// File: rtl/mrs_margin_reg.sv
`timescale 1ns/1ns
`include "mrs_defs.svh"
module mrs_margin_reg #(
	parameter logic [15:0] MIN = 16'h0000,
	parameter logic [15:0] MAX = 16'h0000,
	parameter logic [15:0] RST0 = 16'h0000,
	parameter logic [15:0] RST1 = 16'h0000
) (
	// Clocking
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	// Update controls
	input wire logic wr_in,
	input wire logic [15:0] wdata_in,
	input wire logic restore_in,
	input wire logic sel_in,
	// Contents
	output logic [15:0] value_out,
	output logic oor_out
);
	typedef struct packed
	{
		logic [15:0] val;
	} mrs_mreg_t;
	mrs_mreg_t s;
	mrs_mreg_t next_s;
	logic lo;
	logic hi;
	// ==========================================================
	// Saturation of out-of-range writes
	assign lo = $signed(wdata_in) < $signed(MIN);
	assign hi = $signed(wdata_in) > $signed(MAX);
	assign oor_out = lo | hi;
	assign value_out = s.val;
	// Whole word is clamped, so fixed high bits come out right by range
	always_comb
	begin
		next_s = s;
		if (ce_in && restore_in)
			next_s.val = sel_in ? RST1 : RST0;
		else if (ce_in && wr_in)
			next_s.val = lo ? MIN : (hi ? MAX : wdata_in);
	end
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			s <= '{val: RST0};
		else
			s <= next_s;
	end
	// ==========================================================
	// Checks
	property p_in_range;
		@(posedge clk_in) disable iff (!rst_b_in)
		$signed(value_out) >= $signed(MIN) && $signed(value_out) <= $signed(MAX);
	endproperty
	a_in_range: assert property (p_in_range) else $error("margin value out of range");
	property p_restore;
		@(posedge clk_in) disable iff (!rst_b_in)
		ce_in && restore_in |=> value_out == ($past(sel_in) ? RST1 : RST0);
	endproperty
	a_restore: assert property (p_restore) else $error("restore preset wrong");
endmodule

// File: rtl/mrs_ref_ramp.sv
`timescale 1ns/1ns
module mrs_ref_ramp (
	// Clocking
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	// Reference link
	mrs_ramp_if.ramp rif
);
	typedef struct packed
	{
		logic [15:0] cur;
		logic [15:0] cnt;
	} mrs_ramp_t;
	mrs_ramp_t s;
	mrs_ramp_t next_s;
	assign rif.current = s.cur;
	// One step per step_div+1 cycles toward the target
	always_comb
	begin
		next_s = s;
		if (ce_in && rif.run)
		begin
			if (s.cur == rif.target)
				next_s.cnt = 16'h0000;
			else if (s.cnt >= rif.step_div)
			begin
				next_s.cnt = 16'h0000;
				next_s.cur = (s.cur < rif.target) ? s.cur + 16'h0001 : s.cur - 16'h0001;
			end
			else
				next_s.cnt = s.cnt + 16'h0001;
		end
	end
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			s <= '0;
		else
			s <= next_s;
	end
	property p_one_step;
		@(posedge clk_in) disable iff (!rst_b_in)
		1'b1 |=> (s.cur == $past(s.cur)) || (s.cur == $past(s.cur) + 16'h0001)
			|| (s.cur == $past(s.cur) - 16'h0001);
	endproperty
	a_one_step: assert property (p_one_step) else $error("reference jumped");
endmodule

// File: rtl/mrs_top.sv
`timescale 1ns/1ns
`include "mrs_defs.svh"
module mrs_top (
	// Clock, reset and enable
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	// Command port from the bus engine
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_wdata_in,
	// Answer to the bus engine
	output logic rsp_valid_out,
	output logic rsp_ack_out,
	output logic [15:0] rsp_rdata_out,
	// Configuration
	input wire logic loop_slave_in,
	input wire logic restore_in,
	input wire logic high_restore_select_in,
	input wire logic low_restore_select_in,
	input wire logic clear_faults_in,
	// Operation margin selects
	input wire logic margin_high_in,
	input wire logic margin_low_in,
	// Reference sources and bounds
	input wire logic [15:0] vout_command_in,
	input wire logic [7:0] vout_scale_loop_in,
	input wire logic [7:0] trim_in,
	input wire logic [15:0] vout_max_in,
	input wire logic [15:0] vout_min_in,
	// Converter state and ramp rates
	input wire logic [3:0] conv_state_in,
	input wire logic [15:0] ton_rise_div_in,
	input wire logic [15:0] transition_div_in,
	input wire logic [15:0] toff_fall_div_in,
	// Status
	output logic cml_out,
	output logic invalid_data_out,
	output logic invalid_command_fault_out,
	output logic smbalert_out,
	// Reference
	output logic [15:0] loop_reference_target_out,
	output logic [15:0] loop_reference_voltage_out
);
	// ==========================================================
	// State
	typedef struct packed
	{
		mrs_pkg::mrs_fsm_t fsm;
		logic rsp_valid;
		logic rsp_ack;
		logic [15:0] rsp_rdata;
		logic cml;
		logic inv_data;
		logic invalid_command_fault;
		logic alert;
		logic [15:0] target;
		logic [15:0] step_div;
		logic run;
	} mrs_top_t;
	mrs_top_t s;
	mrs_top_t next_s;

	// ==========================================================
	// Decoding used by the sequencer and the write enables
	function automatic logic is_margin_cmd(input logic [7:0] code);
		is_margin_cmd = (code == `MRS_CMD_POS) || (code == `MRS_CMD_NEG);
	endfunction

	logic acc;
	logic acc_wr;
	logic wr_pos;
	logic wr_neg;
	logic oor_pos;
	logic oor_neg;
	logic [15:0] pos_val;
	logic [15:0] neg_val;
	logic [23:0] scaled;
	logic signed [18:0] sum;
	logic signed [18:0] bmax;
	logic signed [18:0] bmin;

	mrs_ramp_if rif ();

	// Request taken only while idle and enabled
	assign acc = ce_in && cmd_valid_in && s.fsm == mrs_pkg::MRS_IDLE && is_margin_cmd(cmd_code_in);
	assign acc_wr = acc && cmd_write_in && !loop_slave_in;
	assign wr_pos = acc_wr && cmd_code_in == `MRS_CMD_POS;
	assign wr_neg = acc_wr && cmd_code_in == `MRS_CMD_NEG;

	// ==========================================================
	// Margin registers
	mrs_margin_reg #(
		.MIN(`MRS_POS_MIN),
		.MAX(`MRS_POS_MAX),
		.RST0(`MRS_POS_RST0),
		.RST1(`MRS_POS_RST1)
	) u_pos (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.ce_in(ce_in),
		.wr_in(wr_pos),
		.wdata_in(cmd_wdata_in),
		.restore_in(restore_in),
		.sel_in(high_restore_select_in),
		.value_out(pos_val),
		.oor_out(oor_pos)
	);
	mrs_margin_reg #(
		.MIN(`MRS_NEG_MIN),
		.MAX(`MRS_NEG_MAX),
		.RST0(`MRS_NEG_RST0),
		.RST1(`MRS_NEG_RST1)
	) u_neg (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.ce_in(ce_in),
		.wr_in(wr_neg),
		.wdata_in(cmd_wdata_in),
		.restore_in(restore_in),
		.sel_in(low_restore_select_in),
		.value_out(neg_val),
		.oor_out(oor_neg)
	);

	// ==========================================================
	// Reference arithmetic, all in 1.953 mV steps
	// Scale is unsigned with seven fraction bits; product fits 24 bits
	assign scaled = vout_command_in * {8'h00, vout_scale_loop_in};
	// Trim and the low margin count are sign-extended, the high margin count zero-extended, before the sum
	always_comb
	begin
		sum = $signed({2'b00, scaled[23:7]});
		sum = sum + $signed({{11{trim_in[7]}}, trim_in});
		if (margin_high_in)
			sum = sum + $signed({3'b000, pos_val});
		if (margin_low_in)
			sum = sum + $signed({{3{neg_val[15]}}, neg_val});
	end
	assign bmax = $signed({3'b000, vout_max_in});
	assign bmin = $signed({3'b000, vout_min_in});

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		next_s = s;
		if (ce_in)
		begin
			// Sequencer: one answer per taken request
			unique case (s.fsm)
				mrs_pkg::MRS_IDLE:
				begin
					next_s.rsp_valid = 1'b0;
					if (acc)
					begin
						next_s.fsm = mrs_pkg::MRS_RESP;
						next_s.rsp_valid = 1'b1;
						next_s.rsp_ack = !loop_slave_in;
						if (loop_slave_in || cmd_write_in)
							next_s.rsp_rdata = 16'h0000;
						else if (cmd_code_in == `MRS_CMD_POS)
							next_s.rsp_rdata = pos_val;
						else
							next_s.rsp_rdata = neg_val;
					end
				end
				mrs_pkg::MRS_RESP:
				begin
					next_s.fsm = mrs_pkg::MRS_IDLE;
					next_s.rsp_valid = 1'b0;
				end
			endcase

			// Sticky flags: a set in the clearing cycle wins
			next_s.invalid_command_fault = (s.invalid_command_fault && !clear_faults_in) || (acc && loop_slave_in);
			next_s.inv_data = (s.inv_data && !clear_faults_in)
				|| (wr_pos && oor_pos) || (wr_neg && oor_neg);
			next_s.cml = (s.cml && !clear_faults_in) || next_s.inv_data;
			next_s.alert = next_s.cml || next_s.invalid_command_fault;

			// Bounded reference target
			if (sum > bmax)
				next_s.target = vout_max_in;
			else if (sum < bmin)
				next_s.target = vout_min_in;
			else if (sum < 19'sd0)
				next_s.target = 16'h0000;
			else
				next_s.target = sum[15:0];

			// Ramp rate by converter state; unknown state holds the reference
			next_s.run = 1'b1;
			unique case (conv_state_in)
				mrs_pkg::MRS_SOFT_START: next_s.step_div = ton_rise_div_in;
				mrs_pkg::MRS_STEADY: next_s.step_div = transition_div_in;
				mrs_pkg::MRS_TOFF_DELAY: next_s.step_div = transition_div_in;
				mrs_pkg::MRS_SOFT_STOP: next_s.step_div = toff_fall_div_in;
				default:
				begin
					next_s.step_div = s.step_div;
					next_s.run = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			s <= '0;
			s.fsm <= mrs_pkg::MRS_IDLE;
		end
		else
			s <= next_s;
	end

	// ==========================================================
	// Ramp engine
	assign rif.target = s.target;
	assign rif.step_div = s.step_div;
	assign rif.run = s.run;
	mrs_ref_ramp u_ramp (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.ce_in(ce_in),
		.rif(rif)
	);

	// Outputs straight from flip-flops
	assign rsp_valid_out = s.rsp_valid;
	assign rsp_ack_out = s.rsp_ack;
	assign rsp_rdata_out = s.rsp_rdata;
	assign cml_out = s.cml;
	assign invalid_data_out = s.inv_data;
	assign invalid_command_fault_out = s.invalid_command_fault;
	assign smbalert_out = s.alert;
	assign loop_reference_target_out = s.target;
	assign loop_reference_voltage_out = rif.current;

	// ==========================================================
	// Checks
	property p_slave_nack;
		@(posedge clk_in) disable iff (!rst_b_in)
		acc && loop_slave_in |=> rsp_valid_out && !rsp_ack_out
			&& invalid_command_fault_out && smbalert_out;
	endproperty
	a_slave_nack: assert property (p_slave_nack) else $error("slave access not refused");

	property p_slave_keep;
		@(posedge clk_in) disable iff (!rst_b_in)
		acc && loop_slave_in && !restore_in |=> pos_val == $past(pos_val)
			&& neg_val == $past(neg_val);
	endproperty
	a_slave_keep: assert property (p_slave_keep) else $error("slave write changed margin");

	property p_clamp_flags;
		@(posedge clk_in) disable iff (!rst_b_in)
		(wr_pos && oor_pos) || (wr_neg && oor_neg) |=> cml_out && invalid_data_out
			&& smbalert_out;
	endproperty
	a_clamp_flags: assert property (p_clamp_flags) else $error("clamp flags missing");

	property p_bounded;
		@(posedge clk_in) disable iff (!rst_b_in)
		ce_in && vout_min_in <= vout_max_in |=> loop_reference_target_out <= $past(vout_max_in)
			&& loop_reference_target_out >= $past(vout_min_in);
	endproperty
	a_bounded: assert property (p_bounded) else $error("target outside bounds");

	property p_hi_byte;
		@(posedge clk_in) disable iff (!rst_b_in)
		rsp_valid_out && rsp_ack_out |-> rsp_rdata_out[15:8] == 8'h00
			|| rsp_rdata_out[15:8] == 8'hff;
	endproperty
	a_hi_byte: assert property (p_hi_byte) else $error("fixed high byte wrong");

	property p_one_answer;
		@(posedge clk_in) disable iff (!rst_b_in)
		rsp_valid_out |=> !rsp_valid_out;
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("answer held too long");

	property p_margin_high;
		@(posedge clk_in) disable iff (!rst_b_in)
		ce_in && margin_high_in && !margin_low_in && sum >= bmin && sum <= bmax
			&& sum >= 19'sd0 |=> loop_reference_target_out
			== 16'($past(scaled[23:7]) + {{8{$past(trim_in[7])}}, $past(trim_in)}
			+ $past(pos_val));
	endproperty
	a_margin_high: assert property (p_margin_high) else $error("margin high not applied");

	property p_margin_low;
		@(posedge clk_in) disable iff (!rst_b_in)
		ce_in && margin_low_in && !margin_high_in && sum >= bmin && sum <= bmax
			&& sum >= 19'sd0 |=> loop_reference_target_out
			== 16'($past(scaled[23:7]) + {{8{$past(trim_in[7])}}, $past(trim_in)}
			+ $past(neg_val));
	endproperty
	a_margin_low: assert property (p_margin_low) else $error("margin low not applied");

	// Clock enable low holds every piece of state
	property p_freeze;
		@(posedge clk_in) disable iff (!rst_b_in)
		!ce_in |=> rsp_valid_out == $past(rsp_valid_out) && smbalert_out == $past(smbalert_out)
			&& pos_val == $past(pos_val) && neg_val == $past(neg_val)
			&& loop_reference_target_out == $past(loop_reference_target_out)
			&& loop_reference_voltage_out == $past(loop_reference_voltage_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	property p_fixed_bits;
		@(posedge clk_in) disable iff (!rst_b_in)
		pos_val[15:5] == 11'h000 && neg_val[15:6] == 10'h3ff;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits wrong");

	// Unknown converter state must not move the reference
	property p_hold_ref;
		@(posedge clk_in) disable iff (!rst_b_in)
		ce_in && !s.run
			|=> loop_reference_voltage_out == $past(loop_reference_voltage_out);
	endproperty
	a_hold_ref: assert property (p_hold_ref) else $error("reference moved while held");

	property p_other_code;
		@(posedge clk_in) disable iff (!rst_b_in)
		ce_in && cmd_valid_in && s.fsm == mrs_pkg::MRS_IDLE && !is_margin_cmd(cmd_code_in)
			|=> !rsp_valid_out;
	endproperty
	a_other_code: assert property (p_other_code) else $error("foreign code answered");

	property p_write_ack;
		@(posedge clk_in) disable iff (!rst_b_in)
		acc_wr |=> rsp_valid_out && rsp_ack_out
			&& rsp_rdata_out == 16'h0000;
	endproperty
	a_write_ack: assert property (p_write_ack) else $error("write not acknowledged");

	property p_clear;
		@(posedge clk_in) disable iff (!rst_b_in)
		ce_in && clear_faults_in && !(acc && loop_slave_in) |=> !invalid_command_fault_out
			&& (smbalert_out == cml_out);
	endproperty
	a_clear: assert property (p_clear) else $error("fault not cleared");
endmodule

// File: dv/mrs_host_model.sv
`timescale 1ns/1ns
module mrs_host_model (
	// Clock and answer
	input wire logic clk_in,
	input wire logic rsp_valid_in,
	// Request
	output logic cmd_valid_out,
	output logic cmd_write_out,
	output logic [7:0] cmd_code_out,
	output logic [15:0] cmd_wdata_out
);
	// ==========
	// Idle until the first request
	initial
	begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_wdata_out = 16'h0000;
	end
	// Whole word per transfer, held until the answer edge
	task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data,
		output logic got);
		got = 1'b0;
		@(posedge clk_in);
		cmd_valid_out <= 1'b1;
		cmd_write_out <= wr;
		cmd_code_out <= code;
		cmd_wdata_out <= data;
		for (int i = 0; i < 4 && !got; i++)
		begin
			@(posedge clk_in);
			got = (rsp_valid_in === 1'b1);
		end
		// Released lines show inverted leftovers, never a stale match
		cmd_valid_out <= 1'b0;
		cmd_write_out <= ~wr;
		cmd_code_out <= ~code;
		cmd_wdata_out <= ~data;
	endtask
endmodule

// File: dv/reference_margin_step_regs_tb.sv
`timescale 1ns/1ns
`include "mrs_defs.svh"
module reference_margin_step_regs_tb;
	logic clk_in, rst_b_in, wr_v, rd_v, ack, restore_in, hsel, lsel, clr_in, slave, ce;
	logic mh, ml, sm, id, ic, al, wd_al;
	logic [7:0] code, sc, trim;
	logic [15:0] wd, rdata, vcmd, vmax, vmin, tgt, volt, pos_v, neg_v;
	logic [15:0] d0, d1, d2;
	logic [3:0] st;
	logic [16:0] exp_q[$];
	logic [15:0] tab_d[8];
	logic [15:0] tab_e[8];
	int fail_count, checked;
	// ==========
	// Clock
	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	mrs_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce), .cmd_valid_in(rd_v),
		.cmd_write_in(wr_v), .cmd_code_in(code), .cmd_wdata_in(wd), .rsp_valid_out(ack),
		.rsp_ack_out(sm), .rsp_rdata_out(rdata), .loop_slave_in(slave),
		.restore_in(restore_in), .high_restore_select_in(hsel), .low_restore_select_in(lsel),
		.clear_faults_in(clr_in), .margin_high_in(mh), .margin_low_in(ml),
		.vout_command_in(vcmd), .vout_scale_loop_in(sc), .trim_in(trim), .vout_max_in(vmax),
		.vout_min_in(vmin), .conv_state_in(st), .ton_rise_div_in(d0),
		.transition_div_in(d1), .toff_fall_div_in(d2), .cml_out(id),
		.invalid_data_out(ic), .invalid_command_fault_out(al), .smbalert_out(wd_al),
		.loop_reference_target_out(tgt), .loop_reference_voltage_out(volt));
	mrs_host_model i_host (.clk_in(clk_in), .rsp_valid_in(ack), .cmd_valid_out(rd_v),
		.cmd_write_out(wr_v), .cmd_code_out(code), .cmd_wdata_out(wd));
	// ==========
	// Comparison and verdict
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Answers are matched oldest first against the driver's notes
	always @(posedge clk_in)
	begin
		if (ack === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(17'h1, 17'h0);
			else
				check({sm, rdata}, exp_q.pop_front());
		end
	end
	// ==========
	// Transfers
	task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
		input logic [16:0] e, input logic answer);
		logic g;
		if (answer)
			exp_q.push_back(e);
		i_host.access(w, c, d, g);
		check({16'h0000, g}, {16'h0000, answer});
		if (answer && g !== 1'b1)
			conclude();
		@(negedge clk_in);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		acc(1'b0, c, 16'h0000, {1'b1, e}, 1'b1);
	endtask
	task automatic flags(input logic [3:0] e);
		check({13'h0000, id, ic, al, wd_al}, {13'h0000, e});
	endtask
	// Clears sticky flags, one cycle wide
	task automatic clr();
		@(posedge clk_in);
		clr_in <= 1'b1;
		@(posedge clk_in);
		clr_in <= 1'b0;
		@(negedge clk_in);
	endtask
	// Bounded reference: scaled command, trim -3, margins, then limits
	task automatic setref(input int c, input int s, input int h, input int l, input int mn,
		input int mx);
		int t;
		@(posedge clk_in);
		vcmd <= c[15:0];
		sc <= s[7:0];
		mh <= h[0];
		ml <= l[0];
		vmin <= mn[15:0];
		vmax <= mx[15:0];
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		t = ((c * s) >>> 7) - 3 + h * int'(pos_v) + l * int'($signed(neg_v));
		t = (t < 0) ? 0 : t;
		t = (t < mn) ? mn : ((t > mx) ? mx : t);
		check({1'b0, tgt}, {1'b0, t[15:0]});
	endtask
	// Ramp time follows the divider of the state given
	task automatic ramp(input logic [3:0] s, input int dv);
		int n, d;
		n = 0;
		d = int'(tgt) - int'(volt);
		d = (d < 0) ? -d : d;
		@(posedge clk_in);
		st <= s;
		while (volt !== tgt && n < 2000)
		begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 2000)
		begin
			check(17'h1, 17'h0);
			conclude();
		end
		check({16'h0000, n >= d * (dv + 1) - dv - 2 && n <= d * (dv + 1) + dv + 2}, 17'h1);
		st <= 4'h0;
	endtask
	// ==========
	// Main sequence
	initial
	begin
		rst_b_in = 1'b0;
		{restore_in, hsel, lsel, clr_in, slave, mh, ml, trim, st} = '0;
		{vcmd, vmin, d0} = '0;
		sc = 8'h80;
		ce = 1'b1;
		vmax = 16'hffff;
		d1 = 16'h0003;
		d2 = 16'h0001;
		trim = 8'hfd;
		void'($urandom(39));
		repeat (12) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rd(`MRS_CMD_POS, `MRS_POS_RST0);
		rd(`MRS_CMD_NEG, `MRS_NEG_RST0);
		for (int s = 1; s >= 0; s--)
		begin
			@(posedge clk_in);
			hsel <= s[0];
			lsel <= s[0];
			@(posedge clk_in);
			restore_in <= 1'b1;
			@(posedge clk_in);
			restore_in <= 1'b0;
			rd(`MRS_CMD_POS, s ? `MRS_POS_RST1 : `MRS_POS_RST0);
			rd(`MRS_CMD_NEG, s ? `MRS_NEG_RST1 : `MRS_NEG_RST0);
		end
		// Boundaries, random legal words, saturation both ways
		tab_d = '{16'h001f, 16'h0030, 16'hfff0, 16'h0000, 16'hffc0, 16'h0005, 16'hff00, 16'h0};
		tab_e = '{16'h001f, 16'h001f, 16'h0000, 16'h0000, 16'hffc0, 16'hffff, 16'hffc0, 16'h0};
		tab_d[3] = 16'($urandom % 32);
		tab_e[3] = tab_d[3];
		tab_d[7] = 16'hffc0 | 16'($urandom % 64);
		tab_e[7] = tab_d[7];
		for (int i = 0; i < 8; i++)
		begin
			clr();
			flags(4'h0);
			acc(1'b1, (i < 4) ? `MRS_CMD_POS : `MRS_CMD_NEG, tab_d[i], 17'h10000, 1'b1);
			flags((tab_d[i] === tab_e[i]) ? 4'h0 : 4'hd);
			rd((i < 4) ? `MRS_CMD_POS : `MRS_CMD_NEG, tab_e[i]);
		end
		pos_v = tab_e[3];
		neg_v = tab_e[7];
		// Loop slave refuses both access kinds
		clr();
		@(posedge clk_in);
		slave <= 1'b1;
		acc(1'b1, `MRS_CMD_POS, 16'h0001, 17'h00000, 1'b1);
		acc(1'b0, `MRS_CMD_NEG, 16'h0000, 17'h00000, 1'b1);
		flags(4'h3);
		@(posedge clk_in);
		slave <= 1'b0;
		rd(`MRS_CMD_POS, pos_v);
		acc(1'b0, 8'hd7, 16'h0000, 17'h0, 1'b0);
		// Reference targets, then ramps per state
		setref(256, 128, 1, 0, 0, 65535);
		setref(256, 64, 1, 0, 0, 65535);
		setref(256, 128, 0, 1, 0, 65535);
		setref(256, 128, 1, 0, 0, 240);
		setref(256, 128, 0, 1, 384, 65535);
		check({1'b0, volt}, 17'h0);
		setref(256, 128, 1, 0, 0, 65535);
		ramp(4'b0001, 0);
		setref(256, 128, 0, 1, 0, 65535);
		ramp(4'b0010, 3);
		setref(384, 128, 0, 1, 0, 65535);
		ramp(4'b0100, 3);
		setref(64, 128, 0, 0, 0, 65535);
		ramp(4'b1000, 1);
		// Clock enable low freezes target and ramp despite new inputs
		@(posedge clk_in);
		ce <= 1'b0;
		vcmd <= 16'h0100 | 16'($urandom % 256);
		st <= 4'b0010;
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		check({1'b0, tgt}, {1'b0, 16'd61});
		check({1'b0, volt}, {1'b0, 16'd61});
		@(posedge clk_in);
		ce <= 1'b1;
		vcmd <= 16'h0040;
		st <= 4'h0;
		check({1'b0, 16'(exp_q.size())}, 17'h0);
		conclude();
	end
endmodule
